// ---- reset_cause_and_register_init.sv ----
// Reset-cause recording and special-register initialisation with Avalon-MM access
// Behaviour
// - Power-on and a low external reset pin both put the core in reset.
// - Watchdog time-out resets only while the watchdog is enabled.
// - Power-on clears wake flag, sets time-out and power-down flags.
// - Pin reset while running clears wake flag, keeps time-out and power-down.
// - Pin reset from sleep clears wake, sets time-out, clears power-down.
// - Watchdog reset while running clears wake and time-out, sets power-down.
// - Watchdog wake from sleep clears all three flags.
// - Pin-change wake sets wake and time-out flags, clears power-down.
// - Clear instruction sets T and P; sleep sets T, clears P.
// - Scratch RAM is not initialised and survives pin, watchdog and wake resets.
`timescale 1ns/10ps

module reset_cause_and_register_init
    import reset_init_pkg::*;
(
    input  wire logic        clk_in,              // Core clock, 100 MHz
    input  wire logic        rst_b_in,            // Power-on reset, async, active low
    input  wire logic        ext_reset_b_in,      // External reset pin, active low
    input  wire logic        wdt_enable_in,       // Watchdog enabled
    input  wire logic        wdt_timeout_in,      // Watchdog time-out pulse
    input  wire logic        watchdog_clear_instruction_exec_in,        // Watchdog-clear instruction pulse
    input  wire logic        sleep_exec_in,       // Sleep instruction pulse
    input  wire logic        pin_change_in,       // Input pin change pulse
    input  wire logic        conv_done_in,        // Conversion complete pulse
    input  wire logic [11:0] conv_result_in,      // Conversion result
    input  wire logic [7:0]  int_request_in,      // Interrupt request pulses
    input  wire logic [8:0]  avs_address_in,      // Byte address
    input  wire logic        avs_read_in,         // Read request
    input  wire logic        avs_write_in,        // Write request
    input  wire logic [31:0] avs_writedata_in,    // Write data
    input  wire logic [3:0]  avs_byteenable_in,   // Byte enables
    output logic      [31:0] avs_readdata_out,    // Read data
    output logic             avs_waitrequest_out, // Wait request
    output logic             core_reset_out,      // Core held in reset
    output logic             sleeping_out,        // Core is asleep
    output logic             wake_flag_out,       // Pin-change wake flag
    output logic             timeout_flag_out,    // Time-out flag
    output logic             power_down_flag_out, // Power-down flag
    output logic             bank_select_out,     // Bank select bit
    output logic      [7:0]  port5_out,           // Port five data
    output logic      [7:0]  port6_out,           // Port six data
    output logic      [7:0]  port7_out,           // Port seven data
    output logic      [3:0]  analog_enable_out,   // Analog input enables
    output logic      [7:0]  conv_control_out,    // Converter control
    output logic      [7:0]  conv_offset_out,     // Converter offset calibration
    output logic             irq_out              // Event interrupt, active high
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic         pin_s1;
        logic         pin_s2;
        logic         pin_s3;
        logic         pin_low;
        logic         sleeping;
        logic         core_rst;
        cause_flags_t flags;
        logic [7:0]   bank;
        logic [7:0]   port5;
        logic [7:0]   port6;
        logic [7:0]   port7;
        logic [7:0]   aisel;
        logic [7:0]   convctl;
        logic [7:0]   convofs;
        logic [7:0]   resup;
        logic [7:0]   reshi;
        logic [7:0]   reslo;
        logic [7:0]   istat2;
        logic [7:0]   istat1;
        events_t      evt_stat;
        events_t      evt_en;
        logic         irq;
        logic         waitreq;
        logic [31:0]  rdata;
    } state_t;

    localparam state_t STATE_RST = '{
        pin_s1:   1'b0,
        pin_s2:   1'b0,
        pin_s3:   1'b0,
        pin_low:  1'b1,
        sleeping: 1'b0,
        core_rst: 1'b1,
        flags:    '{wake: 1'b0, timeout: 1'b1, power_down: 1'b1},
        bank:     RST_BANK,
        port5:    RST_PORT5,
        port6:    RST_PORT6,
        port7:    RST_PORT7,
        aisel:    RST_ZERO,
        convctl:  RST_ZERO,
        convofs:  RST_ZERO,
        resup:    RST_ZERO,
        reshi:    RST_ZERO,
        reslo:    RST_ZERO,
        istat2:   RST_ZERO,
        istat1:   RST_ZERO,
        evt_stat: RST_EVT,
        evt_en:   5'h00,
        irq:      1'b0,
        waitreq:  1'b1,
        rdata:    32'h0000_0000
    };

    state_t     st_reg;
    state_t     st_next;
    logic [7:0] ram [IDX_RAM_LO:IDX_RAM_HI];

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Widen a byte to a bus word
    function automatic logic [31:0] word(input logic [7:0] b);
        return {24'h00_0000, b};
    endfunction

    // Byte-lane write into the implemented bits only
    function automatic logic [7:0] wr8(input logic [7:0] old,
                                       input logic [7:0] data,
                                       input logic [7:0] mask);
        return (old & ~mask) | (data & mask);
    endfunction

    logic [6:0] idx;
    logic       commit;
    logic       wr_ok;
    logic       ram_hit;
    logic       pin_fall;
    logic       wdt_fire;
    logic       wdt_wake;
    logic       pin_wake;
    logic       soft_rst;
    logic [7:0] wd;

    assign idx     = avs_address_in[8:2];
    assign wd      = avs_writedata_in[7:0];
    assign ram_hit = (idx >= IDX_RAM_LO) && (idx <= IDX_RAM_HI);
    // A write takes effect at the edge where waitrequest is seen low
    assign commit  = ~st_reg.waitreq & (avs_read_in | avs_write_in);
    assign wr_ok   = commit & avs_write_in & avs_byteenable_in[0];

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_next = st_reg;

        // Pin synchroniser; level counts once stages two and three agree
        st_next.pin_s1 = ext_reset_b_in;
        st_next.pin_s2 = st_reg.pin_s1;
        st_next.pin_s3 = st_reg.pin_s2;
        if (st_reg.pin_s2 == st_reg.pin_s3) begin
            st_next.pin_low = ~st_reg.pin_s3;
        end
        pin_fall = st_next.pin_low & ~st_reg.pin_low;

        wdt_fire = wdt_timeout_in & wdt_enable_in;
        wdt_wake = wdt_fire & st_reg.sleeping;
        pin_wake = pin_change_in & st_reg.sleeping & ~st_reg.pin_low & ~wdt_fire;
        // Pin held low or watchdog fire
        soft_rst = st_next.pin_low | wdt_fire;

        // Cause flags, highest priority last
        if (watchdog_clear_instruction_exec_in) begin
            st_next.flags.timeout    = 1'b1;
            st_next.flags.power_down = 1'b1;
        end
        if (sleep_exec_in & ~st_reg.core_rst) begin
            st_next.flags.timeout    = 1'b1;
            st_next.flags.power_down = 1'b0;
            st_next.sleeping         = 1'b1;
        end
        if (pin_wake) begin
            st_next.flags    = '{wake: 1'b1, timeout: 1'b1, power_down: 1'b0};
            st_next.sleeping = 1'b0;
            st_next.bank[POS_BANK_HI] = 1'b0;
        end
        if (wdt_fire & ~pin_fall) begin
            if (st_reg.sleeping) begin
                st_next.flags = '{wake: 1'b0, timeout: 1'b0, power_down: 1'b0};
            end else begin
                st_next.flags = '{wake: 1'b0, timeout: 1'b0, power_down: 1'b1};
            end
            st_next.sleeping = 1'b0;
        end
        if (pin_fall) begin
            if (st_reg.sleeping) begin
                st_next.flags = '{wake: 1'b0, timeout: 1'b1, power_down: 1'b0};
            end else begin
                st_next.flags.wake = 1'b0;
            end
            st_next.sleeping = 1'b0;
        end

        // Software writes to special registers
        if (wr_ok && !st_reg.core_rst) begin
            unique case (idx)
                IDX_BANK:    st_next.bank    = wd;
                IDX_PORT5:   st_next.port5   = wd;
                IDX_PORT6:   st_next.port6   = wd;
                IDX_PORT7:   st_next.port7   = wr8(st_reg.port7, wd, MASK_PORT7);
                IDX_AISEL:   st_next.aisel   = wr8(st_reg.aisel, wd, MASK_AISEL);
                IDX_CONVCTL: begin
                    st_next.convctl = wr8(st_reg.convctl, wd, MASK_CONV);
                    // Run bit can be set but not cleared by software
                    st_next.convctl[POS_CONV_RUN] = st_reg.convctl[POS_CONV_RUN]
                                                    | wd[POS_CONV_RUN];
                end
                IDX_CONVOFS: st_next.convofs = wr8(st_reg.convofs, wd, MASK_OFS);
                IDX_ISTAT2:  st_next.istat2  = wr8(st_reg.istat2, wd, MASK_IST2);
                IDX_ISTAT1:  st_next.istat1  = wd;
                IDX_EVT_EN:  st_next.evt_en  = wd[4:0];
                IDX_EVT_CLR: st_next.evt_stat = st_reg.evt_stat & ~wd[4:0];
                default: ;
            endcase
        end

        // Hardware sets win over software clears
        st_next.istat1 = st_next.istat1 | int_request_in;
        if (conv_done_in) begin
            st_next.resup = conv_result_in[11:4];
            st_next.reshi = {4'h0, conv_result_in[11:8]};
            st_next.reslo = conv_result_in[7:0];
            st_next.istat2[POS_CONV_DONE] = 1'b1;
            st_next.convctl[POS_CONV_RUN] = 1'b0;
        end

        if (soft_rst) begin
            st_next.bank[POS_BANK_HI]  = 1'b0;
            st_next.bank[POS_BANK_SEL] = 1'b0;
            st_next.port5   = RST_PORT5;
            st_next.port6   = RST_PORT6;
            st_next.port7   = RST_PORT7;
            st_next.aisel   = RST_ZERO;
            st_next.convctl = RST_ZERO;
            st_next.convofs = RST_ZERO;
            st_next.istat2  = RST_ZERO;
            st_next.istat1  = RST_ZERO;
        end

        // Sticky events
        st_next.evt_stat.pin_reset = st_next.evt_stat.pin_reset | pin_fall;
        st_next.evt_stat.wdt_reset = st_next.evt_stat.wdt_reset
                                     | (wdt_fire & ~st_reg.sleeping);
        st_next.evt_stat.wdt_wake  = st_next.evt_stat.wdt_wake | wdt_wake;
        st_next.evt_stat.pin_wake  = st_next.evt_stat.pin_wake | pin_wake;
        st_next.irq = |(st_next.evt_stat & st_next.evt_en);

        // Core reset released on a clock edge
        st_next.core_rst = soft_rst;

        // Bus handshake: one wait cycle, then answer
        if (!st_reg.waitreq) begin
            st_next.waitreq = 1'b1;
        end else if (avs_read_in | avs_write_in) begin
            st_next.waitreq = 1'b0;
            st_next.rdata   = 32'h0000_0000;
            if (avs_read_in) begin
                if (ram_hit) begin
                    st_next.rdata = word(ram[idx]);
                end else begin
                    unique case (idx)
                        IDX_STATUS:   st_next.rdata = word({st_reg.flags.wake, 2'b00,
                                                   st_reg.flags.timeout,
                                                   st_reg.flags.power_down, 3'b000});
                        IDX_BANK:     st_next.rdata = word(st_reg.bank);
                        IDX_PORT5:    st_next.rdata = word(st_reg.port5);
                        IDX_PORT6:    st_next.rdata = word(st_reg.port6);
                        IDX_PORT7:    st_next.rdata = word(st_reg.port7);
                        IDX_AISEL:    st_next.rdata = word(st_reg.aisel);
                        IDX_CONVCTL:  st_next.rdata = word(st_reg.convctl);
                        IDX_CONVOFS:  st_next.rdata = word(st_reg.convofs);
                        IDX_RESUP:    st_next.rdata = word(st_reg.resup);
                        IDX_RESHI:    st_next.rdata = word(st_reg.reshi);
                        IDX_RESLO:    st_next.rdata = word(st_reg.reslo);
                        IDX_ISTAT2:   st_next.rdata = word(st_reg.istat2);
                        IDX_ISTAT1:   st_next.rdata = word(st_reg.istat1);
                        IDX_EVT_STAT: st_next.rdata = word({3'b000, st_reg.evt_stat});
                        IDX_EVT_EN:   st_next.rdata = word({3'b000, st_reg.evt_en});
                        default:      st_next.rdata = 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    // Power-on values of the cause flags
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_reg <= STATE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // Scratch RAM has no reset and ignores soft resets
    always_ff @(posedge clk_in) begin
        if (wr_ok && ram_hit) begin
            ram[idx] <= wd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign avs_readdata_out    = st_reg.rdata;
    assign avs_waitrequest_out = st_reg.waitreq;
    assign core_reset_out      = st_reg.core_rst;
    assign sleeping_out        = st_reg.sleeping;
    assign wake_flag_out       = st_reg.flags.wake;
    assign timeout_flag_out    = st_reg.flags.timeout;
    assign power_down_flag_out = st_reg.flags.power_down;
    assign bank_select_out     = st_reg.bank[POS_BANK_SEL];
    assign port5_out           = st_reg.port5;
    assign port6_out           = st_reg.port6;
    assign port7_out           = st_reg.port7;
    assign analog_enable_out   = st_reg.aisel[3:0];
    assign conv_control_out    = st_reg.convctl;
    assign conv_offset_out     = st_reg.convofs;
    assign irq_out             = st_reg.irq;

endmodule

// ---- reset_init_pkg.sv ----
// Constants and types for the reset-cause and register-init block
package reset_init_pkg;

    // Register indices; byte address is four times the index
    localparam logic [6:0] IDX_STATUS   = 7'h03;
    localparam logic [6:0] IDX_BANK     = 7'h04;
    localparam logic [6:0] IDX_PORT5    = 7'h05;
    localparam logic [6:0] IDX_PORT6    = 7'h06;
    localparam logic [6:0] IDX_PORT7    = 7'h07;
    localparam logic [6:0] IDX_AISEL    = 7'h08;
    localparam logic [6:0] IDX_CONVCTL  = 7'h09;
    localparam logic [6:0] IDX_CONVOFS  = 7'h0A;
    localparam logic [6:0] IDX_RESUP    = 7'h0B;
    localparam logic [6:0] IDX_RESHI    = 7'h0C;
    localparam logic [6:0] IDX_RESLO    = 7'h0D;
    localparam logic [6:0] IDX_ISTAT2   = 7'h0E;
    localparam logic [6:0] IDX_ISTAT1   = 7'h0F;
    localparam logic [6:0] IDX_RAM_LO   = 7'h10;
    localparam logic [6:0] IDX_RAM_HI   = 7'h3F;
    localparam logic [6:0] IDX_EVT_STAT = 7'h40;
    localparam logic [6:0] IDX_EVT_CLR  = 7'h41;
    localparam logic [6:0] IDX_EVT_EN   = 7'h42;

    // Field positions
    localparam int POS_RST_FLAG  = 7;
    localparam int POS_T_FLAG    = 4;
    localparam int POS_P_FLAG    = 3;
    localparam int POS_BANK_HI   = 7;
    localparam int POS_BANK_SEL  = 6;
    localparam int POS_CONV_RUN  = 4;
    localparam int POS_CONV_DONE = 5;

    // Values after reset and implemented-bit masks
    localparam logic [7:0] RST_BANK   = 8'h00;
    localparam logic [7:0] RST_PORT5  = 8'hFF;
    localparam logic [7:0] RST_PORT6  = 8'hFF;
    localparam logic [7:0] RST_PORT7  = 8'h01;
    localparam logic [7:0] RST_ZERO   = 8'h00;
    localparam logic [7:0] MASK_PORT7 = 8'h01;
    localparam logic [7:0] MASK_AISEL = 8'h0F;
    localparam logic [7:0] MASK_CONV  = 8'hFB;
    localparam logic [7:0] MASK_OFS   = 8'hF8;
    localparam logic [7:0] MASK_IST2  = 8'h2A;
    localparam logic [4:0] RST_EVT    = 5'h01;

    // Cause flags as seen by firmware
    typedef struct packed {
        logic wake;
        logic timeout;
        logic power_down;
    } cause_flags_t;

    // Sticky event bits
    typedef struct packed {
        logic wdt_wake;
        logic pin_wake;
        logic wdt_reset;
        logic pin_reset;
        logic power_on;
    } events_t;

endpackage

// ---- reset_cause_checker.sv ----
// Assertions on reset causes, cause flags and wake-up
`timescale 1ns/10ps

module reset_cause_checker
    import reset_init_pkg::*;
(
    input wire logic clk_in,              // Clock
    input wire logic rst_b_in,            // Power-on reset
    input wire logic ext_reset_b_in,      // Reset pin
    input wire logic wdt_enable_in,       // Watchdog on
    input wire logic wdt_timeout_in,      // Time-out
    input wire logic watchdog_clear_instruction_exec_in,        // Clear instr
    input wire logic sleep_exec_in,       // Sleep instr
    input wire logic pin_change_in,       // Pin change
    input wire logic core_reset_out,      // Core reset
    input wire logic sleeping_out,        // Asleep
    input wire logic wake_flag_out,       // Wake flag
    input wire logic timeout_flag_out,    // T flag
    input wire logic power_down_flag_out, // P flag
    input wire logic irq_out              // Interrupt
);
    logic [2:0] hi_cnt;
    logic       quiet;
    logic [2:0] flags;
    logic       fire;

    // Pin high long enough that no fall is left in the synchroniser
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in)
            hi_cnt <= 3'h0;
        else if (!ext_reset_b_in)
            hi_cnt <= 3'h0;
        else if (hi_cnt != 3'h7)
            hi_cnt <= hi_cnt + 3'h1;
    end
    assign quiet = ext_reset_b_in && hi_cnt == 3'h7;
    assign flags = {wake_flag_out, timeout_flag_out, power_down_flag_out};
    assign fire  = wdt_enable_in && wdt_timeout_in;

    ////////////////////////////////////////
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    AST_POR_FLAGS: assert property (
        $rose(rst_b_in) |-> core_reset_out && flags == 3'b011) else $error("bad power-on flags");
    AST_PIN_HOLDS: assert property (
        !ext_reset_b_in [*6] |-> core_reset_out) else $error("pin low without reset");
    AST_WDT_OFF: assert property (
        quiet && !wdt_enable_in && wdt_timeout_in && !core_reset_out |=> !core_reset_out)
        else $error("reset from disabled watchdog");
    AST_PIN_RUN: assert property (
        quiet && !sleeping_out ##1 !ext_reset_b_in [*6] |-> !wake_flag_out
        && flags[1:0] == {$past(timeout_flag_out, 6), $past(power_down_flag_out, 6)})
        else $error("bad flags after pin reset");
    AST_PIN_SLEEP: assert property (
        quiet && sleeping_out ##1 !ext_reset_b_in [*6] |-> flags == 3'b010 && !sleeping_out)
        else $error("bad flags after pin wake reset");
    AST_WDT_RUN: assert property (
        quiet && fire && !sleeping_out && !core_reset_out |=> core_reset_out && flags == 3'b001)
        else $error("bad watchdog reset");
    AST_WDT_WAKE: assert property (
        quiet && fire && sleeping_out |=> !sleeping_out && flags == 3'b000)
        else $error("bad watchdog wake");
    AST_PIN_WAKE: assert property (
        quiet && pin_change_in && sleeping_out && !fire |=> !sleeping_out && flags == 3'b110)
        else $error("bad pin-change wake");
    AST_SLEEP: assert property (
        quiet && sleep_exec_in && !sleeping_out && !core_reset_out && !fire
        |=> sleeping_out && flags[1:0] == 2'b10 && $stable(wake_flag_out)) else $error("bad sleep");
    AST_CLEAR: assert property (
        quiet && watchdog_clear_instruction_exec_in && !sleep_exec_in && !sleeping_out && !core_reset_out && !fire
        |=> flags[1:0] == 2'b11 && $stable(wake_flag_out)) else $error("bad clear");

    COV_WDT_WAKE: cover property (fire && sleeping_out);
    COV_PIN_WAKE: cover property (pin_change_in && sleeping_out);
    COV_IRQ: cover property ($rose(irq_out));
endmodule

bind reset_cause_and_register_init reset_cause_checker i_reset_cause_checker (.*);

// ---- reset_partner_model.sv ----
// Model of the external reset pin and the watchdog counter
`timescale 1ns/10ps

module reset_partner_model
    import reset_init_pkg::*;
(
    input  wire logic clk_in,          // Clock
    output logic      ext_reset_b_out, // Reset pin, active low
    output logic      wdt_timeout_out  // Time-out pulse
);
    initial begin
        ext_reset_b_out = 1'b1;
        wdt_timeout_out = 1'b0;
    end

    task automatic hold_pin_low(input int cycles);
        @(posedge clk_in);
        ext_reset_b_out <= 1'b0;
        repeat (cycles) @(posedge clk_in);
        ext_reset_b_out <= 1'b1;
    endtask

    // counter fires whether enabled or not
    task automatic expire(input int period);
        repeat (period) @(posedge clk_in);
        wdt_timeout_out <= 1'b1;
        @(posedge clk_in);
        wdt_timeout_out <= 1'b0;
    endtask
endmodule

// ---- tb_reset_cause_and_register_init.sv ----
// Self-checking bench for the reset-cause and register-init block
`timescale 1ns/10ps

module tb_reset_cause_and_register_init
    import reset_init_pkg::*;
;
    logic        clk_in = 1'b0;
    logic        rst_b_in, ext_reset_b_in, wdt_enable_in, wdt_timeout_in, watchdog_clear_instruction_exec_in;
    logic        sleep_exec_in, pin_change_in, conv_done_in, avs_read_in, avs_write_in;
    logic        avs_waitrequest_out, core_reset_out, sleeping_out, wake_flag_out;
    logic        timeout_flag_out, power_down_flag_out, bank_select_out, irq_out;
    logic [11:0] conv_result_in, res;
    logic [7:0]  int_request_in, port5_out, port6_out, port7_out, q;
    logic [7:0]  conv_control_out, conv_offset_out, regs [6], ram [4];
    logic [6:0]  ram_idx [4];
    logic [3:0]  avs_byteenable_in, analog_enable_out;
    logic [8:0]  avs_address_in;
    logic [31:0] avs_writedata_in, avs_readdata_out;
    int          failures = 0;
    int          n_tests = 0;
    logic        ms = 1'b0;
    cause_flags_t mf = 3'b011;
    int          evs [13] = '{4, 3, 2, 5, 1, 0, 3, 0, 3, 1, 3, 2, 4};
    localparam logic [6:0] SIDX [6] = '{IDX_PORT5, IDX_PORT6, IDX_PORT7, IDX_AISEL,
                                        IDX_CONVCTL, IDX_CONVOFS};
    localparam logic [7:0] SMSK [6] = '{8'hFF, 8'hFF, MASK_PORT7, MASK_AISEL, MASK_CONV, MASK_OFS};
    localparam logic [7:0] SDEF [6] = '{RST_PORT5, RST_PORT6, RST_PORT7, RST_ZERO, RST_ZERO,
                                        RST_ZERO};

    always #5 clk_in = ~clk_in;

    reset_partner_model i_reset_partner_model (
        .clk_in          (clk_in),
        .ext_reset_b_out (ext_reset_b_in),
        .wdt_timeout_out (wdt_timeout_in)
    );
    reset_cause_and_register_init i_reset_cause_and_register_init (.*);

    ////////////////////////////////////////
    function automatic cause_flags_t exp_flags(input int ev, input logic slp,
                                               input cause_flags_t p);
        case (ev)
            0: return slp ? 3'b010 : {1'b0, p.timeout, p.power_down};
            1: return slp ? 3'b000 : 3'b001;
            2: return slp ? 3'b110 : p;
            3: return {p.wake, 2'b10};
            4: return {p.wake, 2'b11};
            default: return p;
        endcase
    endfunction

    function automatic logic [7:0] stat_byte(input cause_flags_t f);
        return {f.wake, 2'b00, f.timeout, f.power_down, 3'b000};
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] want);
        n_tests++;
        if (got !== want) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask

    // Request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [6:0] idx, input logic [7:0] d,
                       output logic [7:0] x);
        @(posedge clk_in);
        avs_address_in <= {idx, 2'b00};
        avs_write_in <= wr;
        avs_read_in <= !wr;
        avs_writedata_in <= {24'h0, d};
        do begin
            @(posedge clk_in);
        end while (avs_waitrequest_out !== 1'b0);
        x = avs_readdata_out[7:0];
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask

    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, idx, d, x);
    endtask

    task automatic rd(input logic [6:0] idx, input logic [7:0] e);
        logic [7:0] x;
        bus(1'b0, idx, 8'h00, x);
        check(x, e);
    endtask

    task automatic irq_is(input logic e);
        repeat (2) @(posedge clk_in);
        check({7'h0, irq_out}, {7'h0, e});
    endtask

    task automatic settle();
        do begin
            @(posedge clk_in);
        end while (core_reset_out !== 1'b0);
    endtask

    task automatic por();
        rst_b_in <= 1'b0;
        repeat (16) @(posedge clk_in);
        rst_b_in <= 1'b1;
        settle();
    endtask

    task automatic check_defaults();
        for (int i = 0; i < 6; i++)
            rd(SIDX[i], SDEF[i]);
        rd(IDX_BANK, RST_BANK);
        rd(IDX_ISTAT1, RST_ZERO);
        rd(IDX_ISTAT2, RST_ZERO);
    endtask

    task automatic event_and_check(input int ev);
        cause_flags_t e;
        repeat (8) @(posedge clk_in);
        e = exp_flags(ev, ms, mf);
        wdt_enable_in <= ev != 5;
        case (ev)
            0: i_reset_partner_model.hold_pin_low($urandom_range(6, 12));
            1, 5: i_reset_partner_model.expire($urandom_range(1, 20));
            default: begin
                {pin_change_in, sleep_exec_in, watchdog_clear_instruction_exec_in} <= 3'b100 >> (ev - 2);
                @(posedge clk_in);
                {pin_change_in, sleep_exec_in, watchdog_clear_instruction_exec_in} <= 3'b000;
            end
        endcase
        repeat (2) @(posedge clk_in);
        settle();
        check({5'h0, wake_flag_out, timeout_flag_out, power_down_flag_out}, {5'h0, e});
        rd(IDX_STATUS, stat_byte(e));
        ms = ev == 3 || (ev > 3 && ms);
        mf = e;
        check({7'h0, sleeping_out}, {7'h0, ms});
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    ////////////////////////////////////////
    initial begin
        {rst_b_in, wdt_enable_in, watchdog_clear_instruction_exec_in, sleep_exec_in, pin_change_in} = '0;
        {conv_done_in, avs_read_in, avs_write_in, conv_result_in, int_request_in} = '0;
        {avs_address_in, avs_writedata_in} = '0;
        avs_byteenable_in = 4'hF;
        void'($urandom(46379));
        por();
        rd(IDX_STATUS, stat_byte(3'b011));
        check_defaults();
        rd(IDX_EVT_STAT, {3'h0, RST_EVT});
        rd(7'h50, 8'h00);
        wr(IDX_EVT_EN, 8'h00);
        irq_is(1'b0);
        wr(IDX_EVT_EN, 8'h1F);
        irq_is(1'b1);
        wr(IDX_EVT_CLR, 8'h1F);
        irq_is(1'b0);
        for (int i = 0; i < 6; i++) begin
            regs[i] = 8'($urandom);
            wr(SIDX[i], regs[i]);
            rd(SIDX[i], regs[i] & SMSK[i]);
        end
        check(port5_out, regs[0]);
        check(port6_out, regs[1]);
        check(port7_out, regs[2] & MASK_PORT7);
        check({4'h0, analog_enable_out}, regs[3] & MASK_AISEL);
        check(conv_control_out, regs[4] & MASK_CONV);
        check(conv_offset_out, regs[5] & MASK_OFS);
        wr(IDX_BANK, 8'hC0);
        rd(IDX_BANK, 8'hC0);
        check({7'h0, bank_select_out}, 8'h01);
        for (int i = 0; i < 4; i++) begin
            ram_idx[i] = i == 0 ? IDX_RAM_LO : i == 3 ? IDX_RAM_HI : 7'(24 + 8 * i + $urandom % 8);
            ram[i] = 8'($urandom);
            wr(ram_idx[i], ram[i]);
        end
        res = 12'($urandom);
        q = 8'($urandom);
        conv_result_in <= res;
        conv_done_in <= 1'b1;
        int_request_in <= q;
        @(posedge clk_in);
        {conv_done_in, int_request_in} <= '0;
        rd(IDX_RESUP, res[11:4]);
        rd(IDX_RESHI, {4'h0, res[11:8]});
        rd(IDX_ISTAT2, 8'h20);
        rd(IDX_ISTAT1, q);
        avs_byteenable_in <= 4'hE;
        wr(IDX_PORT5, ~regs[0]);
        avs_byteenable_in <= 4'hF;
        wr(IDX_RESLO, ~res[7:0]);
        rd(IDX_PORT5, regs[0]);
        rd(IDX_RESLO, res[7:0]);
        foreach (evs[i])
            event_and_check(evs[i]);
        check_defaults();
        for (int i = 0; i < 4; i++)
            rd(ram_idx[i], ram[i]);
        rd(IDX_EVT_STAT, 8'h1E);
        por();
        rd(IDX_STATUS, stat_byte(3'b011));
        tally_and_finish();
    end

    // About 430 to 500 cycles expected; far longer means a hang
    initial begin
        #200us;
        failures++;
        tally_and_finish();
    end
endmodule
